// file: hw/gpio_port_b_pkg.sv
// Summary of operation
// - Direction bit 1 makes a pin input; 0 drives it as output, per pin.
// - Data register reads return pin levels; writes load the output latch.
// - Data writes are read-modify-write: pins sampled, merged, stored into latch.
// - Direction bits still govern pins selected as analog inputs.
// - Each pin has a weak pull-up active when its enable bit is 1.
// - Pull-ups work only while global disable is clear; reset sets it.
// - Pull-up is off whenever the pin is output or analog input.
// - Analog-selected pins read back 0 and feed their analog function.
// - Analog selection does not stop an output pin driving its latch.
// - Analog-select bits 7..0 map to analog channels 15..8.
// - Per-pin change interrupt enables; reset leaves all disabled.
// - Enabled pins compared to last-read value; OR of mismatches sets change flag.
// - Persisting mismatch keeps setting the flag; port access ends mismatch.
// - Last-read latch survives undervoltage reset; mismatch then re-sets flag.
// - A change coinciding with a port read does not set the flag.
// - The change flag can wake the device from sleep.
// - Per-pin weak pull-down, off while pin is output or analog input.
// - High-drive bit 1 uses shared level code; 0 fixes 30mA.
// - Low-drive bit 1 gives 120mA sink; 0 gives 60mA.
// - Shared 4-bit code: 0000 is zero, 0001 is 2mA, 1111 is 30mA.
// - Flag sets only from mismatches on pins whose change interrupt enable is 1.
package gpio_port_b_pkg;

  // ****************************************
  // Register indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] IDX_PORT_PIN_DATA = 10'h006;
  localparam logic [9:0] IDX_PORT_DIRECTION = 10'h086;
  localparam logic [9:0] IDX_CHANGE_INTERRUPT_ENABLE = 10'h088;
  localparam logic [9:0] IDX_ANALOG_SELECT_HIGH = 10'h089;
  localparam logic [9:0] IDX_PULL_UP_ENABLE = 10'h095;
  localparam logic [9:0] IDX_PULL_DOWN_ENABLE = 10'h097;
  localparam logic [9:0] IDX_DRIVE_LEVEL_SELECT = 10'h113;
  localparam logic [9:0] IDX_LOW_DRIVE_SELECT = 10'h115;
  localparam logic [9:0] IDX_HIGH_DRIVE_ENABLE = 10'h117;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_PERIPHERAL_FLAG_REGISTER_TWO = 10'h00d;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GLOBAL_PULL_UP_DISABLE_BIT = 7;
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int DRIVE_LEVEL_CODE_W = 4;
  localparam int CURRENT_MA_W = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PORT_DIRECTION_RST = 8'hff;
  localparam logic [7:0] CHANGE_INTERRUPT_ENABLE_RST = 8'h00;
  localparam logic [7:0] ANALOG_SELECT_HIGH_RST = 8'h00;
  localparam logic [7:0] PULL_UP_ENABLE_RST = 8'h00;
  localparam logic [7:0] PULL_DOWN_ENABLE_RST = 8'h00;
  localparam logic [3:0] DRIVE_LEVEL_CODE_RST = 4'h0;
  localparam logic [7:0] LOW_DRIVE_SELECT_RST = 8'h00;
  localparam logic [7:0] HIGH_DRIVE_ENABLE_RST = 8'h00;
  localparam logic GLOBAL_PULL_UP_DISABLE_RST = 1'b1;
  localparam logic [7:0] PORT_LATCH_RST = 8'h00;

  // ****************************************
  // Drive currents
  // ****************************************
  localparam logic [3:0] DRIVE_LEVEL_CODE_MAX = 4'hf;
  localparam logic [4:0] HIGH_CURRENT_DEFAULT_MA = 5'h1e;
  localparam int LOW_CURRENT_LARGE_MA = 120;
  localparam int LOW_CURRENT_SMALL_MA = 60;
  localparam int ANALOG_CHANNEL_BASE = 8;

endpackage

// file: hw/gpio_port_b.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module gpio_port_b (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic brownout_rst,
  // Avalon-MM slave
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // Pin conditioning
  output logic [7:0] pull_up_on,
  output logic [7:0] pull_down_on,
  output logic [7:0] analog_en,
  output logic [39:0] high_current_ma,
  output logic [7:0] low_drive_large,
  // Change event
  output logic port_change_flag,
  output logic wake
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] port_latch;
    logic [7:0] direction;
    logic [7:0] change_en;
    logic [7:0] analog_sel;
    logic [7:0] pull_up_en;
    logic [7:0] pull_down_en;
    logic [3:0] drive_level_code;
    logic [7:0] low_drive_sel;
    logic [7:0] high_drive_en;
    logic global_pull_up_disable;
    logic change_flag;
    logic [7:0] last_read;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Current in mA for a drive-level code: two per step
  function automatic logic [4:0] code_to_ma(input logic [3:0] code);
    code_to_ma = {code, 1'b0};
  endfunction

  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx);
  endfunction

  // ****************************************
  // Combinational views
  // ****************************************
  logic [7:0] pin_digital;
  logic [7:0] mismatch;
  logic [7:0] lane_mask;
  logic req;
  logic commit_wr;
  logic commit_rd;
  logic port_access;

  // Analog pins always read 0 on the digital side
  assign pin_digital = s_q.sync2 & ~s_q.analog_sel;
  assign mismatch = (pin_digital ^ s_q.last_read) & s_q.change_en;
  assign lane_mask = byteenable[0] ? 8'hff : 8'h00;
  assign req = read | write;
  assign commit_wr = write & s_q.ack;
  assign commit_rd = read & s_q.ack;
  assign port_access = (commit_wr | commit_rd) & hit(address, gpio_port_b_pkg::IDX_PORT_PIN_DATA);

  // One wait state on every access; the answer is ready the cycle after the request
  assign waitrequest = req & ~s_q.ack;
  assign readdata = s_q.rdata;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.ack = req & ~s_q.ack;

    // Read data is captured while waitrequest is high
    s_d.rdata = 32'h0000_0000;
    if (read & ~s_q.ack) begin
      if (hit(address, gpio_port_b_pkg::IDX_PORT_PIN_DATA)) begin
        s_d.rdata[7:0] = pin_digital;
      end else if (hit(address, gpio_port_b_pkg::IDX_PORT_DIRECTION)) begin
        s_d.rdata[7:0] = s_q.direction;
      end else if (hit(address, gpio_port_b_pkg::IDX_CHANGE_INTERRUPT_ENABLE)) begin
        s_d.rdata[7:0] = s_q.change_en;
      end else if (hit(address, gpio_port_b_pkg::IDX_ANALOG_SELECT_HIGH)) begin
        s_d.rdata[7:0] = s_q.analog_sel;
      end else if (hit(address, gpio_port_b_pkg::IDX_PULL_UP_ENABLE)) begin
        s_d.rdata[7:0] = s_q.pull_up_en;
      end else if (hit(address, gpio_port_b_pkg::IDX_PULL_DOWN_ENABLE)) begin
        s_d.rdata[7:0] = s_q.pull_down_en;
      end else if (hit(address, gpio_port_b_pkg::IDX_DRIVE_LEVEL_SELECT)) begin
        s_d.rdata[3:0] = s_q.drive_level_code;
      end else if (hit(address, gpio_port_b_pkg::IDX_LOW_DRIVE_SELECT)) begin
        s_d.rdata[7:0] = s_q.low_drive_sel;
      end else if (hit(address, gpio_port_b_pkg::IDX_HIGH_DRIVE_ENABLE)) begin
        s_d.rdata[7:0] = s_q.high_drive_en;
      end else if (hit(address, gpio_port_b_pkg::IDX_OPTION)) begin
        s_d.rdata[gpio_port_b_pkg::GLOBAL_PULL_UP_DISABLE_BIT] = s_q.global_pull_up_disable;
      end else if (hit(address, gpio_port_b_pkg::IDX_PERIPHERAL_FLAG_REGISTER_TWO)) begin
        s_d.rdata[gpio_port_b_pkg::PORT_CHANGE_FLAG_BIT] = s_q.change_flag;
      end
    end

    // Any port access refreshes the comparison latch, ending the mismatch
    if (port_access) begin
      s_d.last_read = pin_digital;
    end

    if (commit_wr & byteenable[0]) begin
      if (hit(address, gpio_port_b_pkg::IDX_PORT_DIRECTION)) begin
        s_d.direction = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_CHANGE_INTERRUPT_ENABLE)) begin
        s_d.change_en = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_ANALOG_SELECT_HIGH)) begin
        s_d.analog_sel = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_PULL_UP_ENABLE)) begin
        s_d.pull_up_en = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_PULL_DOWN_ENABLE)) begin
        s_d.pull_down_en = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_DRIVE_LEVEL_SELECT)) begin
        s_d.drive_level_code = writedata[3:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_LOW_DRIVE_SELECT)) begin
        s_d.low_drive_sel = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_HIGH_DRIVE_ENABLE)) begin
        s_d.high_drive_en = writedata[7:0];
      end else if (hit(address, gpio_port_b_pkg::IDX_OPTION)) begin
        s_d.global_pull_up_disable = writedata[gpio_port_b_pkg::GLOBAL_PULL_UP_DISABLE_BIT];
      end
    end

    // Pins are sampled and merged with the written byte; a disabled lane
    // copies pin levels into the latch, which is the read-modify-write hazard
    if (commit_wr & hit(address, gpio_port_b_pkg::IDX_PORT_PIN_DATA)) begin
      s_d.port_latch = (pin_digital & ~lane_mask) | (writedata[7:0] & lane_mask);
    end

    // Software clears by writing 0; a concurrent set still wins
    if (commit_wr & byteenable[0] & hit(address, gpio_port_b_pkg::IDX_PERIPHERAL_FLAG_REGISTER_TWO)) begin
      if (!writedata[gpio_port_b_pkg::PORT_CHANGE_FLAG_BIT]) begin
        s_d.change_flag = 1'b0;
      end
    end
    // A change seen in the access cycle is dropped, like a read in the second phase
    if ((|mismatch) && !port_access) begin
      s_d.change_flag = 1'b1;
    end

    // Undervoltage reset restores the control registers but not the
    // comparison latch, so a lasting mismatch re-sets the flag afterwards
    if (brownout_rst) begin
      s_d.port_latch = s_q.port_latch;
      s_d.direction = gpio_port_b_pkg::PORT_DIRECTION_RST;
      s_d.change_en = gpio_port_b_pkg::CHANGE_INTERRUPT_ENABLE_RST;
      s_d.analog_sel = gpio_port_b_pkg::ANALOG_SELECT_HIGH_RST;
      s_d.pull_up_en = gpio_port_b_pkg::PULL_UP_ENABLE_RST;
      s_d.pull_down_en = gpio_port_b_pkg::PULL_DOWN_ENABLE_RST;
      s_d.drive_level_code = gpio_port_b_pkg::DRIVE_LEVEL_CODE_RST;
      s_d.low_drive_sel = gpio_port_b_pkg::LOW_DRIVE_SELECT_RST;
      s_d.high_drive_en = gpio_port_b_pkg::HIGH_DRIVE_ENABLE_RST;
      s_d.global_pull_up_disable = gpio_port_b_pkg::GLOBAL_PULL_UP_DISABLE_RST;
      s_d.change_flag = 1'b0;
      s_d.last_read = s_q.last_read;
      s_d.ack = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.sync1 <= 8'h00;
      s_q.sync2 <= 8'h00;
      // Latch content is undefined to software; zero only keeps simulation clean
      s_q.port_latch <= gpio_port_b_pkg::PORT_LATCH_RST;
      s_q.direction <= gpio_port_b_pkg::PORT_DIRECTION_RST;
      s_q.change_en <= gpio_port_b_pkg::CHANGE_INTERRUPT_ENABLE_RST;
      s_q.analog_sel <= gpio_port_b_pkg::ANALOG_SELECT_HIGH_RST;
      s_q.pull_up_en <= gpio_port_b_pkg::PULL_UP_ENABLE_RST;
      s_q.pull_down_en <= gpio_port_b_pkg::PULL_DOWN_ENABLE_RST;
      s_q.drive_level_code <= gpio_port_b_pkg::DRIVE_LEVEL_CODE_RST;
      s_q.low_drive_sel <= gpio_port_b_pkg::LOW_DRIVE_SELECT_RST;
      s_q.high_drive_en <= gpio_port_b_pkg::HIGH_DRIVE_ENABLE_RST;
      s_q.global_pull_up_disable <= gpio_port_b_pkg::GLOBAL_PULL_UP_DISABLE_RST;
      s_q.change_flag <= 1'b0;
      s_q.last_read <= 8'h00;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  // Direction alone decides driving, analog selection does not interfere
  assign pin_oe = ~s_q.direction;
  assign pin_out = s_q.port_latch;
  // Bit n feeds analog channel 8 + n
  assign analog_en = s_q.analog_sel;
  assign pull_up_on = s_q.pull_up_en & s_q.direction & ~s_q.analog_sel
                      & {8{~s_q.global_pull_up_disable}};
  assign pull_down_on = s_q.pull_down_en & s_q.direction & ~s_q.analog_sel;
  assign low_drive_large = s_q.low_drive_sel;
  assign port_change_flag = s_q.change_flag;
  assign wake = s_q.change_flag;

  always_comb begin
    high_current_ma = 40'h00_0000_0000;
    for (int i = 0; i < 8; i++) begin
      high_current_ma[i*5 +: 5] = s_q.high_drive_en[i] ? code_to_ma(s_q.drive_level_code)
                                                        : gpio_port_b_pkg::HIGH_CURRENT_DEFAULT_MA;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_DIR_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (write && !waitrequest && byteenable[0] && !brownout_rst && hit(address, gpio_port_b_pkg::IDX_PORT_DIRECTION))
    |=> (pin_oe == ~$past(writedata[7:0])))
    else $error("direction write not reflected on output enables");

  AST_READ_PINS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (read && waitrequest && !brownout_rst && hit(address, gpio_port_b_pkg::IDX_PORT_PIN_DATA))
    |=> (readdata[7:0] == $past(s_q.sync2 & ~s_q.analog_sel)) && !waitrequest)
    else $error("port read does not return digital pin levels");

  AST_RMW_LANE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (write && !waitrequest && !byteenable[0] && !brownout_rst && hit(address, gpio_port_b_pkg::IDX_PORT_PIN_DATA))
    |=> (pin_out == $past(pin_digital)))
    else $error("port write did not load sampled pins into latch");

  AST_PULLUP_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(|(pull_up_on & (pin_oe | analog_en))))
    else $error("pull-up active on output or analog pin");

  AST_GLOBAL_PU: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.global_pull_up_disable |-> (pull_up_on == 8'h00))
    else $error("pull-up active while globally disabled");

  AST_PULLDOWN_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pull_down_on & (pin_oe | analog_en)) == 8'h00)
    else $error("pull-down active on output or analog pin");

  AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((|mismatch) && !port_access && !brownout_rst) |=> port_change_flag [*1] ##1 1'b1)
    else $error("mismatch did not set change flag");

  AST_NO_SET_ON_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!port_change_flag && port_access) |=> !port_change_flag)
    else $error("change flag set in port access cycle");

  AST_LAST_READ_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    brownout_rst |=> $stable(s_q.last_read))
    else $error("comparison latch lost on undervoltage reset");

  AST_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(wake) |-> ($past(|mismatch) && !$past(port_access)))
    else $error("wake raised without a pin mismatch");

  AST_DEFAULT_30MA: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s_q.high_drive_en[0] |-> (high_current_ma[4:0] == gpio_port_b_pkg::HIGH_CURRENT_DEFAULT_MA))
    else $error("pin 0 high current not at default");

  AST_CODE_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.high_drive_en[7] |-> (high_current_ma[39:35] == 5'(2 * s_q.drive_level_code)))
    else $error("pin 7 high current not twice the code");

  AST_ONE_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(read | write) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after exactly one wait state");

endmodule // gpio_port_b

// file: tb/pin_partner_model.sv
`timescale 1ns/10ps
module pin_partner_model (
  // Clock
  input wire logic core_clk,
  // Design side of the pads
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up_on,
  input wire logic [7:0] pull_down_on,
  // Outside drivers set by the bench
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_level
);
  // ****************************************
  // Pad resolution
  // ****************************************
  logic [7:0] float_q;

  // A floating pad wanders every cycle, so a stale level never passes for a driven one
  always @(posedge core_clk) begin
    float_q <= (float_q === 8'h5a) ? 8'ha5 : 8'h5a;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else if (pull_up_on[i]) begin
        pin_level[i] = 1'b1;
      end else if (pull_down_on[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_q[i];
      end
    end
  end
endmodule // pin_partner_model

// file: tb/test_eight_bit_gpio_port_b.sv
`timescale 1ns/10ps
module test_eight_bit_gpio_port_b;
  logic core_clk, rst_n, brownout_rst, read, write, waitrequest, port_change_flag, wake;
  logic [11:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic [7:0] pin_level, pin_out, pin_oe, pull_up_on, pull_down_on, analog_en, low_drive_large, ext_en, ext_val;
  logic [39:0] high_current_ma;
  logic [31:0] exp_q [$];
  logic [7:0] v [8];
  logic [7:0] x, d, pins;
  int fail_count = 0;
  int samples_checked = 0;
  logic [9:0] reg_idx [8] = '{gpio_port_b_pkg::IDX_PORT_DIRECTION, gpio_port_b_pkg::IDX_CHANGE_INTERRUPT_ENABLE,
    gpio_port_b_pkg::IDX_ANALOG_SELECT_HIGH, gpio_port_b_pkg::IDX_PULL_UP_ENABLE,
    gpio_port_b_pkg::IDX_PULL_DOWN_ENABLE, gpio_port_b_pkg::IDX_DRIVE_LEVEL_SELECT,
    gpio_port_b_pkg::IDX_LOW_DRIVE_SELECT, gpio_port_b_pkg::IDX_HIGH_DRIVE_ENABLE};
  logic [7:0] reg_rst [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] reg_mask [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};

  gpio_port_b gpio_port_b_i (.core_clk(core_clk), .rst_n(rst_n), .brownout_rst(brownout_rst),
    .address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .pull_down_on(pull_down_on), .analog_en(analog_en),
    .high_current_ma(high_current_ma), .low_drive_large(low_drive_large),
    .port_change_flag(port_change_flag), .wake(wake));

  pin_partner_model pin_partner_model_i (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .pull_down_on(pull_down_on), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(pin_level));

  // ****************************************
  // Bus tasks and comparisons
  // ****************************************
  task automatic bus_wr(input logic [9:0] idx, input logic [7:0] data, input logic be0);
    @(posedge core_clk);
    address <= {idx, 2'h0};
    byteenable <= {3'h0, be0};
    writedata <= {24'h0, data};
    write <= 1'b1;
    @(posedge core_clk);
    while (waitrequest) @(posedge core_clk);
    write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [9:0] idx, input logic [7:0] exp);
    @(posedge core_clk);
    address <= {idx, 2'h0};
    read <= 1'b1;
    exp_q.push_back({24'h0, exp});
    @(posedge core_clk);
    while (waitrequest) @(posedge core_clk);
    read <= 1'b0;
  endtask

  task automatic compare_read(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch time=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic compare_pin(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch time=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Change the outside level, let the two sync stages and the flag settle, then look
  task automatic flag_after(input logic [7:0] val, input logic exp);
    @(posedge core_clk);
    ext_val <= val;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    compare_pin({wake, port_change_flag}, {exp, exp});
  endtask

  function automatic logic [39:0] hi_ma(input logic [7:0] en, input logic [3:0] code);
    for (int i = 0; i < 8; i++) hi_ma[5*i +: 5] = en[i] ? {code, 1'b0} : 5'h1e;
  endfunction

  task automatic report_and_stop;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) compare_read(readdata, exp_q.pop_front());
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    brownout_rst = 1'b0;
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
    ext_en = 8'hff;
    ext_val = 8'h00;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    void'($urandom(86));
    foreach (reg_idx[i]) bus_rd(reg_idx[i], reg_rst[i]);
    bus_wr(10'h3ff, 8'hff, 1'b1);
    bus_rd(10'h3ff, 8'h00);
    bus_rd(gpio_port_b_pkg::IDX_OPTION, 8'h80);
    bus_wr(gpio_port_b_pkg::IDX_PULL_UP_ENABLE, 8'hff, 1'b0);
    bus_rd(gpio_port_b_pkg::IDX_PULL_UP_ENABLE, 8'h00);
    repeat (6) begin
      foreach (v[i]) v[i] = 8'($urandom());
      v[2] = v[2] & v[0];
      x = 8'($urandom());
      @(posedge core_clk);
      ext_en <= v[0];
      ext_val <= x;
      bus_wr(gpio_port_b_pkg::IDX_OPTION, 8'h80, 1'b1);
      foreach (reg_idx[i]) bus_wr(reg_idx[i], v[i], 1'b1);
      foreach (reg_idx[i]) bus_rd(reg_idx[i], v[i] & reg_mask[i]);
      @(negedge core_clk);
      compare_pin(pin_oe, 8'(~v[0]));
      compare_pin(analog_en, v[2]);
      compare_pin(pull_up_on, 8'h00);
      compare_pin(pull_down_on, v[4] & v[0] & ~v[2]);
      compare_pin(low_drive_large, v[6]);
      compare_pin(high_current_ma, hi_ma(v[7], v[5][3:0]));
      bus_wr(gpio_port_b_pkg::IDX_OPTION, 8'h00, 1'b1);
      @(negedge core_clk);
      compare_pin(pull_up_on, v[3] & v[0] & ~v[2]);
      d = 8'($urandom());
      bus_wr(gpio_port_b_pkg::IDX_PORT_PIN_DATA, d, 1'b1);
      @(negedge core_clk);
      compare_pin(pin_out, d);
      pins = ~v[2] & ((~v[0] & d) | (v[0] & x));
      repeat (2) @(posedge core_clk);
      bus_rd(gpio_port_b_pkg::IDX_PORT_PIN_DATA, pins);
      bus_wr(gpio_port_b_pkg::IDX_PORT_PIN_DATA, 8'h00, 1'b0);
      @(negedge core_clk);
      compare_pin(pin_out & ~v[2], pins);
    end
    @(posedge core_clk);
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    bus_wr(gpio_port_b_pkg::IDX_PORT_DIRECTION, 8'hff, 1'b1);
    bus_wr(gpio_port_b_pkg::IDX_ANALOG_SELECT_HIGH, 8'h00, 1'b1);
    bus_wr(gpio_port_b_pkg::IDX_CHANGE_INTERRUPT_ENABLE, 8'h01, 1'b1);
    repeat (3) @(posedge core_clk);
    bus_rd(gpio_port_b_pkg::IDX_PORT_PIN_DATA, 8'h00);
    bus_wr(gpio_port_b_pkg::IDX_PERIPHERAL_FLAG_REGISTER_TWO, 8'h00, 1'b1);
    flag_after(8'h02, 1'b0);
    flag_after(8'h03, 1'b1);
    bus_wr(gpio_port_b_pkg::IDX_PERIPHERAL_FLAG_REGISTER_TWO, 8'h00, 1'b1);
    flag_after(8'h03, 1'b1);
    bus_rd(gpio_port_b_pkg::IDX_PERIPHERAL_FLAG_REGISTER_TWO, 8'h01);
    @(posedge core_clk);
    brownout_rst <= 1'b1;
    @(posedge core_clk);
    brownout_rst <= 1'b0;
    bus_rd(gpio_port_b_pkg::IDX_CHANGE_INTERRUPT_ENABLE, 8'h00);
    bus_wr(gpio_port_b_pkg::IDX_CHANGE_INTERRUPT_ENABLE, 8'h01, 1'b1);
    flag_after(8'h03, 1'b1);
    bus_rd(gpio_port_b_pkg::IDX_PORT_PIN_DATA, 8'h03);
    bus_wr(gpio_port_b_pkg::IDX_PERIPHERAL_FLAG_REGISTER_TWO, 8'h00, 1'b1);
    flag_after(8'h03, 1'b0);
    bus_wr(gpio_port_b_pkg::IDX_PORT_PIN_DATA, 8'ha5, 1'b1);
    bus_wr(gpio_port_b_pkg::IDX_PORT_DIRECTION, 8'h00, 1'b1);
    bus_wr(gpio_port_b_pkg::IDX_ANALOG_SELECT_HIGH, 8'hff, 1'b1);
    ext_en <= 8'h00;
    @(negedge core_clk);
    compare_pin({pin_oe, pin_out}, 16'hffa5);
    compare_pin({pull_up_on, pull_down_on}, 16'h0000);
    report_and_stop;
  end
endmodule // test_eight_bit_gpio_port_b
